/* core/gab_address_mode.v */
// address recognition mode logic of the bus interface core
//
// Notes on behaviour
// (R1) mode field picks one of four modes
// (R2) mode zero: talk-only and listen-only drive functions
// (R3) host keeps only-bits and mode exclusive
// (R4) mode 1: major slot zero, minor slot one
// (R5) dual modes report major or minor received
// (R6) single address: disable minor talker and listener
// (R7) mode 2: primary then secondary, no host
// (R8) mode 2: primary vs slot zero, secondary slot one
// (R9) mode 3: dual primaries each need secondary
// (R10) mode 3 secondary: pending flag and latch
// (R11) hold accept-data until valid or non-valid
// (R12) host checks secondary, answers valid or not
// (R13) host writes zero to unused mode bits
// (R14) host sets both transceiver mode bits
// (R15) valid is 0f, non-valid is 07
// (R16) valid addresses and releases; non-valid only releases; non-valid here also clears talker_addressed for a held talker
`timescale 1ns/100ps
`default_nettype none
`include "gab_defines.vh"
module gab_address_mode
(
   input wire sys_clk,
   input wire rst,
   input wire [1:0] address_mode_select,
   input wire talk_only,
   input wire listen_only,
   input wire [7:0] address_slot_zero,
   input wire [7:0] address_slot_one,
   input wire [7:0] cmd_byte,
   input wire cmd_valid,
   input wire aux_wr,
   input wire [7:0] auxiliary_command_port,
   input wire transceiver_mode_high,
   input wire transceiver_mode_low,
   input wire controller_in_charge,
   input wire pullup_enable,
   output reg talker_addressed,
   output reg listener_addressed,
   output reg talker_primary_addressed_state,
   output reg listener_primary_addressed_state,
   output reg major_minor_indicator,
   output reg secondary_pending_flag,
   output reg [7:0] command_passthrough_latch,
   output reg accept_data_state,
   output reg transceiver_ctrl_two,
   output reg transceiver_ctrl_three
);
   // ----------------------------------------
   // command decode
   // ----------------------------------------
   wire [1:0] grp = cmd_byte[6:5];
   wire [4:0] adr = cmd_byte[4:0];
   wire take = cmd_valid & ~accept_data_state;
   wire is_lsn = take & (grp == `GAB_GRP_LISTEN);
   wire is_tlk = take & (grp == `GAB_GRP_TALK);
   wire is_sec = take & (grp == `GAB_GRP_SECONDARY);
   wire unaddr = (adr == `GAB_UN_ADDR);
   wire hit_maj = (adr == address_slot_zero[4:0]); // R4 R8
   wire hit_min = (adr == address_slot_one[4:0]); // R4
   wire dual = address_mode_select[0]; // R1
   // minor slot only counts in dual modes; disable bits gate each function
   wire tlk_maj = hit_maj & ~address_slot_zero[`GAB_SLOT_TD]; // R6
   wire tlk_min = dual & hit_min & ~address_slot_one[`GAB_SLOT_TD]; // R6
   wire lsn_maj = hit_maj & ~address_slot_zero[`GAB_SLOT_LD];
   wire lsn_min = dual & hit_min & ~address_slot_one[`GAB_SLOT_LD];
   wire aux_valid = aux_wr & (auxiliary_command_port == `GAB_AUX_VALID); // R15
   wire aux_nonvalid = aux_wr & (auxiliary_command_port == `GAB_AUX_NONVALID); // R15
   // remembers whether the held secondary arrived with talker or listener primary
   reg held_tlk;
   reg held_lsn;

   // ----------------------------------------
   // addressing state
   // ----------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         talker_addressed <= 1'h0;
         listener_addressed <= 1'h0;
         talker_primary_addressed_state <= 1'h0;
         listener_primary_addressed_state <= 1'h0;
         major_minor_indicator <= 1'h0;
         secondary_pending_flag <= 1'h0;
         command_passthrough_latch <= `GAB_BYTE_ZERO;
         accept_data_state <= 1'h0;
         held_tlk <= 1'h0;
         held_lsn <= 1'h0;
         transceiver_ctrl_two <= 1'h0;
         transceiver_ctrl_three <= 1'h0;
      end
      else
      begin
         // both mode bits set route controller and pull-up onto the two outputs
         transceiver_ctrl_two <= transceiver_mode_high & transceiver_mode_low & controller_in_charge; // R14
         transceiver_ctrl_three <= transceiver_mode_high & transceiver_mode_low & pullup_enable; // R14
         case (address_mode_select)
            `GAB_MODE_TLO:
            begin
               // bus addresses ignored entirely
               talker_addressed <= talk_only; // R2
               listener_addressed <= listen_only; // R2
               talker_primary_addressed_state <= 1'h0;
               listener_primary_addressed_state <= 1'h0;
               accept_data_state <= 1'h0;
               secondary_pending_flag <= 1'h0;
            end
            `GAB_MODE_DUAL:
            begin
               // hold only exists in mode 3; leaving it must not strand the handshake
               accept_data_state <= 1'h0;
               secondary_pending_flag <= 1'h0;
               if (is_lsn)
               begin
                  if (unaddr)
                     listener_addressed <= 1'h0;
                  else if (lsn_maj | lsn_min)
                  begin
                     listener_addressed <= 1'h1; // R4
                     major_minor_indicator <= ~lsn_maj; // R5
                  end
               end
               if (is_tlk)
               begin
                  talker_addressed <= tlk_maj | tlk_min; // R4
                  if (tlk_maj | tlk_min)
                     major_minor_indicator <= ~tlk_maj; // R5
               end
            end
            `GAB_MODE_EXT_SINGLE:
            begin
               // same release of a stranded hold as in mode 1
               accept_data_state <= 1'h0;
               secondary_pending_flag <= 1'h0;
               // secondary must follow the primary directly
               if (is_lsn)
               begin
                  if (unaddr)
                     listener_addressed <= 1'h0;
                  listener_primary_addressed_state <= lsn_maj; // R8
                  talker_primary_addressed_state <= 1'h0;
               end
               else if (is_tlk)
               begin
                  talker_primary_addressed_state <= tlk_maj; // R8
                  listener_primary_addressed_state <= 1'h0;
                  if (!tlk_maj)
                     talker_addressed <= 1'h0;
               end
               else if (is_sec)
               begin
                  if (hit_min & listener_primary_addressed_state)
                     listener_addressed <= 1'h1; // R7 R8
                  if (talker_primary_addressed_state)
                     talker_addressed <= hit_min; // R7
                  talker_primary_addressed_state <= 1'h0;
                  listener_primary_addressed_state <= 1'h0;
               end
               else if (take)
               begin
                  talker_primary_addressed_state <= 1'h0;
                  listener_primary_addressed_state <= 1'h0;
               end
            end
            default:
            begin
               if (accept_data_state)
               begin
                  // handshake frozen until host answers
                  if (aux_valid | aux_nonvalid)
                  begin
                     accept_data_state <= 1'h0; // R11 R16
                     secondary_pending_flag <= 1'h0;
                     talker_primary_addressed_state <= 1'h0;
                     listener_primary_addressed_state <= 1'h0;
                     if (aux_valid & held_lsn)
                        listener_addressed <= 1'h1; // R16
                     if (held_tlk)
                        talker_addressed <= aux_valid; // R16
                  end
               end
               else if (is_lsn)
               begin
                  if (unaddr)
                     listener_addressed <= 1'h0;
                  listener_primary_addressed_state <= lsn_maj | lsn_min; // R9
                  talker_primary_addressed_state <= 1'h0;
                  if (lsn_maj | lsn_min)
                     major_minor_indicator <= ~lsn_maj; // R5
               end
               else if (is_tlk)
               begin
                  talker_primary_addressed_state <= tlk_maj | tlk_min; // R9
                  listener_primary_addressed_state <= 1'h0;
                  if (tlk_maj | tlk_min)
                     major_minor_indicator <= ~tlk_maj; // R5
                  else
                     talker_addressed <= 1'h0;
               end
               else if (is_sec & (talker_primary_addressed_state | listener_primary_addressed_state))
               begin
                  secondary_pending_flag <= 1'h1; // R10
                  command_passthrough_latch <= cmd_byte; // R10
                  accept_data_state <= 1'h1; // R11
                  held_tlk <= talker_primary_addressed_state;
                  held_lsn <= listener_primary_addressed_state;
               end
               else if (take)
               begin
                  talker_primary_addressed_state <= 1'h0;
                  listener_primary_addressed_state <= 1'h0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* core/gab_defines.vh */
// constants for the address mode logic
`ifndef GAB_DEFINES_VH
`define GAB_DEFINES_VH
`define GAB_MODE_TLO 2'h0
`define GAB_MODE_DUAL 2'h1
`define GAB_MODE_EXT_SINGLE 2'h2
`define GAB_MODE_EXT_DUAL 2'h3
`define GAB_AUX_VALID 8'h0f
`define GAB_AUX_NONVALID 8'h07
`define GAB_GRP_LISTEN 2'h1
`define GAB_GRP_TALK 2'h2
`define GAB_GRP_SECONDARY 2'h3
`define GAB_UN_ADDR 5'h1f
`define GAB_SLOT_TD 6
`define GAB_SLOT_LD 5
`define GAB_BYTE_ZERO 8'h00
`endif

/* test/gab_cic_model.sv */
// controller-in-charge model sending bus command bytes
`timescale 1ns/100ps
`default_nettype none
module gab_cic_model
(
   input wire logic sys_clk,
   input wire logic send,
   input wire logic [7:0] send_byte,
   output var logic [7:0] cmd_byte,
   output var logic cmd_valid
);
   initial cmd_valid = 1'h0;
   initial cmd_byte = 8'h00;
   always @(posedge sys_clk)
   begin
      // released lines flip between the last byte and its complement every cycle
      cmd_byte <= send ? send_byte : ~cmd_byte;
      cmd_valid <= send;
   end
endmodule
`default_nettype wire

/* test/gab_address_mode_properties.sv */
// port assertions for the address mode logic
`timescale 1ns/100ps
`default_nettype none
module gab_props
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] address_mode_select,
   input wire logic talk_only,
   input wire logic [7:0] address_slot_zero,
   input wire logic [7:0] address_slot_one,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_valid,
   input wire logic aux_wr,
   input wire logic [7:0] auxiliary_command_port,
   input wire logic talker_addressed,
   input wire logic listener_addressed,
   input wire logic talker_primary_addressed_state,
   input wire logic listener_primary_addressed_state,
   input wire logic major_minor_indicator,
   input wire logic secondary_pending_flag,
   input wire logic [7:0] command_passthrough_latch,
   input wire logic accept_data_state
);
   wire logic [1:0] md = address_mode_select;
   wire logic [6:0] cb = cmd_byte[6:0];
   wire logic take = cmd_valid && !accept_data_state;
   wire logic tp = talker_primary_addressed_state;
   wire logic lp = listener_primary_addressed_state;
   wire logic ok = accept_data_state && aux_wr && auxiliary_command_port == 8'h0f;
   wire logic no = accept_data_state && aux_wr && auxiliary_command_port == 8'h07;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   only_bits_a: assert property (md == 2'h0 |=> talker_addressed == $past(talk_only))
      else $error("only-bit ignored");
   hold_kept_a: assert property (md == 2'h3 && accept_data_state && !ok && !no |=> accept_data_state)
      else $error("hold lost");
   valid_free_a: assert property (ok |=> !accept_data_state && !secondary_pending_flag)
      else $error("valid no release");
   valid_talk_a: assert property (ok && tp |=> talker_addressed) else $error("valid no talk");
   refuse_listen_a: assert property (no && lp |=> !$rose(listener_addressed) && !accept_data_state)
      else $error("non-valid wrong");
   pend_flag_a: assert property (md == 2'h3 && take && (tp || lp) && cb[6:5] == 2'h3 |=>
      secondary_pending_flag && accept_data_state && command_passthrough_latch[6:0] == $past(cb))
      else $error("secondary not held");
   ext_single_a: assert property (md == 2'h2 && take && lp && cb == {2'h3, address_slot_one[4:0]}
      |=> listener_addressed && !lp) else $error("extended listen");
   minor_listen_a: assert property (md == 2'h1 && take && cb == {2'h1, address_slot_one[4:0]}
      && !address_slot_one[5] && cb[4:0] != address_slot_zero[4:0] |=> listener_addressed && major_minor_indicator)
      else $error("minor");
   cover property (ok);
   cover property (no);
   cover property (md == 2'h2 && listener_addressed);
endmodule
bind gab_address_mode gab_props gab_props_i (.*);
`default_nettype wire

/* test/tb_gab_address_mode.sv */
// table-driven bench for the address mode logic
`timescale 1ns/100ps
`default_nettype none
module tb_gab_address_mode;
   logic sys_clk = 1'h0, rst = 1'h1, talk_only = 1'h1, listen_only = 1'h0, aux_wr = 1'h0, send = 1'h0;
   logic controller_in_charge = 1'h1, pullup_enable = 1'h0;
   logic [1:0] address_mode_select = 2'h0;
   logic [3:0] op;
   logic [7:0] address_slot_zero = 8'h00, address_slot_one = 8'h00, auxiliary_command_port, sb, v, e, m;
   wire logic transceiver_mode_high = 1'h1, transceiver_mode_low = 1'h1;
   wire logic cmd_valid, talker_addressed, listener_addressed, talker_primary_addressed_state;
   wire logic listener_primary_addressed_state, major_minor_indicator, secondary_pending_flag;
   wire logic accept_data_state, transceiver_ctrl_two, transceiver_ctrl_three;
   wire logic [7:0] cmd_byte, command_passthrough_latch;
   int failures = 0, samples_checked = 0;
   // op, value, expected {ta,la,tp,lp,mm,pf,ad,t3}, mask
   logic [27:0] st [$] = '{28'h5_02_80_c1, 28'h3_05_00_00, 28'h0_25_80_c0, 28'h5_01_40_c0,
      28'h6_01_01_01, 28'h5_00_00_c0, 28'h4_09_00_00, 28'h2_01_00_00,
      28'h0_45_80_88, 28'h0_29_c8_c8, 28'h4_69_00_00, 28'h0_49_40_c0, 28'h0_3f_00_c0,
      28'h4_03_00_00, 28'h2_02_00_00, 28'h0_25_10_50, 28'h0_63_40_50,
      28'h0_3f_00_40, 28'h0_25_10_50, 28'h0_2a_00_50, 28'h0_63_00_50,
      28'h4_09_00_00, 28'h2_03_00_00, 28'h0_45_20_ae, 28'h0_62_26_26, 28'h0_20_26_26,
      28'h1_02_06_06, 28'h1_0f_80_a6, 28'h0_29_18_58, 28'h0_61_16_56, 28'h1_07_00_56};
   always #2 sys_clk = ~sys_clk;
   gab_address_mode gab_address_mode_i (.*);
   gab_cic_model gab_cic_model_i (.sys_clk, .send, .send_byte(sb), .cmd_byte, .cmd_valid);
   task check(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("%0d checks, %0d failures", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 rst = 1'h0;
      foreach (st[i])
      begin
         {op, v, e, m} = st[i];
         sb = v;
         auxiliary_command_port = v;
         case (op)
            4'h0: send = 1'h1;
            4'h1: aux_wr = 1'h1;
            4'h2: address_mode_select = v[1:0];
            4'h3: address_slot_zero = v;
            4'h4: address_slot_one = v;
            4'h5: {talk_only, listen_only} = v[1:0];
            default: {controller_in_charge, pullup_enable} = v[1:0];
         endcase
         @(posedge sys_clk) #1;
         {send, aux_wr} = 2'h0;
         @(posedge sys_clk) #1;
         check({talker_addressed, listener_addressed, talker_primary_addressed_state,
            listener_primary_addressed_state, major_minor_indicator, secondary_pending_flag,
            accept_data_state, transceiver_ctrl_three} & m, e);
         check({7'h00, transceiver_ctrl_two}, {7'h00, controller_in_charge});
         $display("step %0d done", i);
      end
      check(command_passthrough_latch, 8'h61);
      give_verdict;
   end
   initial
   begin
      #2000;
      failures++;
      give_verdict;
   end
endmodule
`default_nettype wire
